// ---- dcp_pkg.sv ----
package dcp_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int IDX_W     = 6;
	localparam int BUF_DEPTH = 64;
	localparam int WORD_W    = 32;
	localparam int ADDR_W    = 32;
	localparam int SRC_COUNT = 3;
	localparam int ORIGIN_W  = 2;

	// ****************************************
	// Sources of normal jobs, in round-robin order
	// ****************************************
	localparam logic [1:0] SRC_RING  = 2'h0;
	localparam logic [1:0] SRC_QPORT = 2'h1;
	localparam logic [1:0] SRC_INTEG = 2'h2;

	// ****************************************
	// Job control field values
	// ****************************************
	localparam logic [ORIGIN_W-1:0] ORIGIN_JOB_RING   = 2'h0;
	localparam logic [IDX_W-1:0]    FOUR_BURST_WORDS  = 6'h04;
	localparam logic [IDX_W-1:0]    SHORT_BURST_WORDS = 6'h01;
	localparam logic [IDX_W-1:0]    IDX_ONE           = 6'h01;
	localparam logic [1:0]          BYTE_LANE_BITS    = 2'h0;
	localparam int                  ADDR_PAD_W        = ADDR_W - IDX_W - 2;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [1:0] {
		CL_FREE  = 2'b00,
		CL_DRAIN = 2'b01,
		CL_GRANT = 2'b10
	} dcp_claim_t;

	// The engine state code is shown directly in the debug state field.
	typedef enum logic [3:0] {
		ENG_IDLE  = 4'b0000,
		ENG_FETCH = 4'b0001,
		ENG_RUN   = 4'b0010,
		ENG_ERROR = 4'b1101
	} dcp_eng_t;

endpackage : dcp_pkg

// ---- dcp_sched_if.sv ----
interface dcp_sched_if;
	logic [dcp_pkg::SRC_COUNT-1:0] srcValid;
	logic                          allow;
	logic [dcp_pkg::SRC_COUNT-1:0] grant;

	modport arb  (input srcValid, input allow, output grant);
	modport user (output srcValid, output allow, input grant);
endinterface : dcp_sched_if

// ---- dcp_rr_sched.sv ----
module dcp_rr_sched (
	input  wire logic  sys_clk,
	input  wire logic  rst,
	dcp_sched_if.arb   sched
);

	logic [1:0] ptr_reg;
	logic [1:0] ptr_next;
	logic [1:0] cand;
	logic       found;

	function automatic logic [1:0] nextSrc(input logic [1:0] s);
		nextSrc = (s == dcp_pkg::SRC_INTEG) ? dcp_pkg::SRC_RING : 2'(s + 2'h1);
	endfunction : nextSrc

	// ****************************************
	// Round-robin pick: rings, then queue port, then integrity checker.
	// ****************************************
	always_comb begin
		sched.grant = '0;
		ptr_next    = ptr_reg;
		cand        = ptr_reg;
		found       = 1'b0;
		for (int k = 0; k < dcp_pkg::SRC_COUNT; k++) begin
			if (!found && sched.allow && sched.srcValid[cand]) begin
				sched.grant[cand] = 1'b1;
				ptr_next          = nextSrc(cand);
				found             = 1'b1;
			end
			cand = nextSrc(cand);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ptr_reg <= dcp_pkg::SRC_RING;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_rr_turn;
		(sched.allow && sched.srcValid[ptr_reg]) |-> sched.grant[ptr_reg];
	endproperty
	a_rr_turn: assert property (p_rr_turn)
		else $error("Source whose turn it is was skipped.");

	property p_rr_single;
		(sched.grant != '0) |-> $onehot(sched.grant);
	endproperty
	a_rr_single: assert property (p_rr_single)
		else $error("More than one source granted.");

	// Moving past the winner is what keeps one busy source from starving the others.
	property p_rr_rotate;
		sched.grant[ptr_reg] |=> ptr_reg == nextSrc($past(ptr_reg));
	endproperty
	a_rr_rotate: assert property (p_rr_rotate)
		else $error("Pointer did not move past the winner.");

endmodule : dcp_rr_sched

// ---- dcp_claim_port.sv ----
module dcp_claim_port (
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	input  wire logic                            engineClaimRequest,
	output logic                                 engineClaimGranted,
	input  wire logic                            ringJobValid,
	input  wire logic                            queuePortJobValid,
	input  wire logic                            integrityJobValid,
	output logic                                 jobAssign,
	output logic [1:0]                           jobSource,
	input  wire logic                            normalJobDone,
	input  wire logic                            descWrite,
	input  wire logic [dcp_pkg::IDX_W-1:0]       descWriteIndex,
	input  wire logic [dcp_pkg::WORD_W-1:0]      descWriteData,
	input  wire logic [dcp_pkg::ADDR_W-1:0]      descAddress,
	input  wire logic                            jobCtrlWrite,
	input  wire logic                            jobCtrlWholeLoaded,
	input  wire logic                            jobCtrlFourWord,
	input  wire logic [dcp_pkg::ORIGIN_W-1:0]    jobCtrlOrigin,
	input  wire logic                            jobCtrlTrusted,
	input  wire logic                            jobCtrlShareReq,
	input  wire logic [dcp_pkg::IDX_W-1:0]       jobCtrlStartIndex,
	input  wire logic [dcp_pkg::IDX_W-1:0]       jobCtrlLength,
	input  wire logic                            jobCtrlAdvance,
	output logic                                 memFetchReq,
	output logic [dcp_pkg::ADDR_W-1:0]           memFetchAddr,
	input  wire logic                            memFetchAck,
	input  wire logic [dcp_pkg::WORD_W-1:0]      memFetchData,
	input  wire logic                            cmdReady,
	input  wire logic                            cmdError,
	output logic                                 cmdValid,
	output logic [dcp_pkg::WORD_W-1:0]           cmdWord,
	output logic                                 debugValid,
	output logic [3:0]                           engineStateField,
	output logic                                 engineReset,
	output logic                                 keysAvailable,
	output logic                                 sharingAllowed
);

	// ****************************************
	// Claim handshake and normal scheduling
	// ****************************************
	dcp_pkg::dcp_claim_t claim_reg, claim_next;
	logic       granted_reg, granted_next;
	logic       occupied_reg, occupied_next;
	logic       assign_reg, assign_next;
	logic [1:0] source_reg, source_next;
	logic       reset_reg, reset_next;
	logic       keys_reg, keys_next;
	logic       share_reg, share_next;

	dcp_sched_if sched ();

	dcp_rr_sched u_sched (
		.sys_clk (sys_clk),
		.rst     (rst),
		.sched   (sched)
	);

	assign sched.srcValid = {integrityJobValid, queuePortJobValid, ringJobValid};

	// A normal job is offered only to an unclaimed, empty engine.
	assign sched.allow = (claim_reg == dcp_pkg::CL_FREE) && !engineClaimRequest
		&& !occupied_reg;

	always_comb begin
		claim_next    = claim_reg;
		occupied_next = occupied_reg;
		assign_next   = sched.grant != '0;
		source_next   = source_reg;
		reset_next    = 1'b0;
		if (sched.grant[dcp_pkg::SRC_QPORT]) begin
			source_next = dcp_pkg::SRC_QPORT;
		end else if (sched.grant[dcp_pkg::SRC_INTEG]) begin
			source_next = dcp_pkg::SRC_INTEG;
		end else if (sched.grant[dcp_pkg::SRC_RING]) begin
			source_next = dcp_pkg::SRC_RING;
		end
		if (assign_next) begin
			occupied_next = 1'b1;
		end else if (normalJobDone) begin
			occupied_next = 1'b0;
		end
		case (claim_reg)
			dcp_pkg::CL_FREE: begin
				if (engineClaimRequest) begin
					claim_next = dcp_pkg::CL_DRAIN;
				end
			end
			dcp_pkg::CL_DRAIN: begin
				if (!engineClaimRequest) begin
					claim_next = dcp_pkg::CL_FREE;
				end else if (!occupied_reg) begin
					claim_next = dcp_pkg::CL_GRANT;
				end
			end
			dcp_pkg::CL_GRANT: begin
				if (!engineClaimRequest) begin
					claim_next = dcp_pkg::CL_FREE;
					reset_next = 1'b1;
				end
			end
			default: begin
				claim_next = dcp_pkg::CL_FREE;
			end
		endcase
		granted_next = claim_next == dcp_pkg::CL_GRANT;
		keys_next    = claim_next == dcp_pkg::CL_FREE;
		share_next   = claim_next == dcp_pkg::CL_FREE;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			claim_reg    <= dcp_pkg::CL_FREE;
			granted_reg  <= 1'b0;
			occupied_reg <= 1'b0;
			assign_reg   <= 1'b0;
			source_reg   <= dcp_pkg::SRC_RING;
			reset_reg    <= 1'b0;
			keys_reg     <= 1'b1;
			share_reg    <= 1'b1;
		end else begin
			claim_reg    <= claim_next;
			granted_reg  <= granted_next;
			occupied_reg <= occupied_next;
			assign_reg   <= assign_next;
			source_reg   <= source_next;
			reset_reg    <= reset_next;
			keys_reg     <= keys_next;
			share_reg    <= share_next;
		end
	end

	// ****************************************
	// Direct execution engine
	// ****************************************
	dcp_pkg::dcp_eng_t eng_reg, eng_next;
	logic [dcp_pkg::IDX_W-1:0]  pc_reg, pc_next;
	logic [dcp_pkg::IDX_W-1:0]  end_reg, end_next;
	logic [dcp_pkg::IDX_W-1:0]  start_reg, start_next;
	logic [dcp_pkg::ADDR_W-1:0] base_reg, base_next;
	logic                       fetch_reg, fetch_next;
	logic [dcp_pkg::ADDR_W-1:0] faddr_reg, faddr_next;
	logic                       cvalid_reg, cvalid_next;
	logic                       dvalid_reg, dvalid_next;
	logic [dcp_pkg::WORD_W-1:0] cword_reg, cword_next;
	logic [dcp_pkg::WORD_W-1:0] descBuf [dcp_pkg::BUF_DEPTH];
	logic                       bufWe;
	logic [dcp_pkg::IDX_W-1:0]  bufIdx;
	logic [dcp_pkg::WORD_W-1:0] bufData;
	logic [dcp_pkg::IDX_W-1:0]  burst;
	logic [dcp_pkg::IDX_W-1:0]  lastIdx;
	logic [dcp_pkg::IDX_W-1:0]  firstFetch;

	function automatic logic [dcp_pkg::ADDR_W-1:0] wordAddr(
		input logic [dcp_pkg::ADDR_W-1:0] base,
		input logic [dcp_pkg::IDX_W-1:0]  offs
	);
		wordAddr = base + {{dcp_pkg::ADDR_PAD_W{1'b0}}, offs, dcp_pkg::BYTE_LANE_BITS};
	endfunction : wordAddr

	always_comb begin
		eng_next    = eng_reg;
		pc_next     = pc_reg;
		end_next    = end_reg;
		start_next  = start_reg;
		base_next   = base_reg;
		fetch_next  = fetch_reg;
		faddr_next  = faddr_reg;
		cvalid_next = 1'b0;
		cword_next  = cword_reg;
		bufWe       = granted_reg && descWrite;
		bufIdx      = descWriteIndex;
		bufData     = descWriteData;
		burst       = jobCtrlFourWord ? dcp_pkg::FOUR_BURST_WORDS : dcp_pkg::SHORT_BURST_WORDS;
		lastIdx     = dcp_pkg::IDX_W'(jobCtrlStartIndex + jobCtrlLength - dcp_pkg::IDX_ONE);
		firstFetch  = dcp_pkg::IDX_W'(jobCtrlStartIndex + burst);
		case (eng_reg)
			dcp_pkg::ENG_IDLE: begin
				// The shared source index is not a port at all, so it is never checked.
				if (granted_reg && jobCtrlWrite) begin
					start_next = jobCtrlStartIndex;
					end_next   = lastIdx;
					pc_next    = jobCtrlStartIndex;
					base_next  = descAddress;
					if (jobCtrlOrigin != dcp_pkg::ORIGIN_JOB_RING
						|| jobCtrlTrusted || jobCtrlShareReq) begin
						eng_next = dcp_pkg::ENG_ERROR;
					end else if (!jobCtrlWholeLoaded && firstFetch <= lastIdx) begin
						eng_next   = dcp_pkg::ENG_FETCH;
						pc_next    = firstFetch;
						fetch_next = 1'b1;
						faddr_next = wordAddr(descAddress, burst);
					end else begin
						eng_next = dcp_pkg::ENG_RUN;
					end
				end
			end
			dcp_pkg::ENG_FETCH: begin
				// Fetched words overwrite whatever software had put past the burst.
				if (memFetchAck) begin
					bufWe   = 1'b1;
					bufIdx  = pc_reg;
					bufData = memFetchData;
					if (pc_reg == end_reg) begin
						eng_next   = dcp_pkg::ENG_RUN;
						pc_next    = start_reg;
						fetch_next = 1'b0;
					end else begin
						pc_next    = dcp_pkg::IDX_W'(pc_reg + dcp_pkg::IDX_ONE);
						faddr_next = wordAddr(base_reg,
							dcp_pkg::IDX_W'(pc_reg + dcp_pkg::IDX_ONE - start_reg));
					end
				end
			end
			dcp_pkg::ENG_RUN: begin
				if (cmdError) begin
					eng_next = dcp_pkg::ENG_ERROR;
				end else if (cmdReady) begin
					cvalid_next = 1'b1;
					cword_next  = descBuf[pc_reg];
					if (pc_reg == end_reg) begin
						eng_next = dcp_pkg::ENG_IDLE;
					end else begin
						pc_next = dcp_pkg::IDX_W'(pc_reg + dcp_pkg::IDX_ONE);
					end
				end
			end
			dcp_pkg::ENG_ERROR: begin
				if (jobCtrlAdvance) begin
					eng_next = dcp_pkg::ENG_IDLE;
				end
			end
			default: begin
				eng_next = dcp_pkg::ENG_IDLE;
			end
		endcase
		// Release outranks everything: the engine is put back to a clean idle.
		if (!granted_next) begin
			eng_next    = dcp_pkg::ENG_IDLE;
			fetch_next  = 1'b0;
			cvalid_next = 1'b0;
		end
		dvalid_next = eng_next != dcp_pkg::ENG_IDLE;
	end

	always_ff @(posedge sys_clk) begin
		if (bufWe) begin
			descBuf[bufIdx] <= bufData;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eng_reg    <= dcp_pkg::ENG_IDLE;
			pc_reg     <= '0;
			end_reg    <= '0;
			start_reg  <= '0;
			base_reg   <= '0;
			fetch_reg  <= 1'b0;
			faddr_reg  <= '0;
			cvalid_reg <= 1'b0;
			dvalid_reg <= 1'b0;
			cword_reg  <= '0;
		end else begin
			eng_reg    <= eng_next;
			pc_reg     <= pc_next;
			end_reg    <= end_next;
			start_reg  <= start_next;
			base_reg   <= base_next;
			fetch_reg  <= fetch_next;
			faddr_reg  <= faddr_next;
			cvalid_reg <= cvalid_next;
			dvalid_reg <= dvalid_next;
			cword_reg  <= cword_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign engineClaimGranted = granted_reg;
	assign jobAssign          = assign_reg;
	assign jobSource          = source_reg;
	assign engineReset        = reset_reg;
	assign keysAvailable      = keys_reg;
	assign sharingAllowed     = share_reg;
	assign memFetchReq        = fetch_reg;
	assign memFetchAddr       = faddr_reg;
	assign cmdValid           = cvalid_reg;
	assign cmdWord            = cword_reg;
	assign debugValid         = dvalid_reg;
	assign engineStateField   = eng_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_no_assign_claimed;
		engineClaimRequest |=> !jobAssign;
	endproperty
	a_no_assign_claimed: assert property (p_no_assign_claimed)
		else $error("Job assigned while claimed.");
	property p_grant_after_drain;
		$rose(engineClaimGranted) |-> $past(engineClaimRequest) && !$past(occupied_reg);
	endproperty
	a_grant_after_drain: assert property (p_grant_after_drain)
		else $error("Grant while engine busy.");
	// A job-control write counts only while the grant stands on both sides of the edge.
	property p_fetch_rest;
		(eng_reg == dcp_pkg::ENG_IDLE && granted_reg && granted_next && jobCtrlWrite
			&& !jobCtrlWholeLoaded && jobCtrlOrigin == dcp_pkg::ORIGIN_JOB_RING
			&& !jobCtrlTrusted && !jobCtrlShareReq && firstFetch <= lastIdx)
			|=> memFetchReq && engineStateField == 4'h1;
	endproperty
	a_fetch_rest: assert property (p_fetch_rest)
		else $error("Remainder fetch not started.");
	property p_valid_running;
		(eng_reg == dcp_pkg::ENG_RUN || eng_reg == dcp_pkg::ENG_FETCH) |-> debugValid;
	endproperty
	a_valid_running: assert property (p_valid_running)
		else $error("Valid low while running.");
	property p_error_code;
		(eng_reg == dcp_pkg::ENG_RUN && cmdError && granted_next) |=> engineStateField == 4'hd;
	endproperty
	a_error_code: assert property (p_error_code)
		else $error("Error state not shown.");
	sequence s_last_word;
		eng_reg == dcp_pkg::ENG_RUN && !cmdError && cmdReady && pc_reg == end_reg && granted_next;
	endsequence
	property p_done_normal;
		s_last_word |=> engineStateField == 4'h0 && !debugValid && cmdValid;
	endproperty
	a_done_normal: assert property (p_done_normal)
		else $error("Completion not shown.");
	sequence s_release;
		engineClaimGranted && !engineClaimRequest;
	endsequence
	property p_release;
		s_release |=> engineReset && !engineClaimGranted && keysAvailable ##1 !engineReset;
	endproperty
	a_release: assert property (p_release)
		else $error("Release did not reset engine.");
	property p_keys_locked;
		engineClaimGranted |-> !keysAvailable && !sharingAllowed;
	endproperty
	a_keys_locked: assert property (p_keys_locked)
		else $error("Keys exposed while claimed.");
	property p_trusted_refused;
		(eng_reg == dcp_pkg::ENG_IDLE && granted_reg && granted_next && jobCtrlWrite
			&& jobCtrlTrusted) |=> engineStateField == 4'hd;
	endproperty
	a_trusted_refused: assert property (p_trusted_refused)
		else $error("Trusted job ran.");
	property p_origin_refused;
		(eng_reg == dcp_pkg::ENG_IDLE && granted_reg && granted_next && jobCtrlWrite
			&& jobCtrlOrigin != dcp_pkg::ORIGIN_JOB_RING) |=> engineStateField == 4'hd;
	endproperty
	a_origin_refused: assert property (p_origin_refused)
		else $error("Foreign origin ran.");
	property p_advance;
		(eng_reg == dcp_pkg::ENG_ERROR && jobCtrlAdvance) |=> engineStateField == 4'h0;
	endproperty
	a_advance: assert property (p_advance)
		else $error("Advance did not clear error.");
	property p_ungranted_idle;
		(!engineClaimGranted && jobCtrlWrite) |=> engineStateField == 4'h0;
	endproperty
	a_ungranted_idle: assert property (p_ungranted_idle)
		else $error("Job started without grant.");

endmodule : dcp_claim_port

// ---- test_dcp_claim_port.sv ----
module test_dcp_claim_port;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Stimulus and observation
	// ****************************************
	logic        sys_clk, rst, engineClaimRequest, engineClaimGranted, jobAssign;
	logic        ringJobValid, queuePortJobValid, integrityJobValid, normalJobDone;
	logic        descWrite, jobCtrlWrite, jobCtrlWholeLoaded, jobCtrlFourWord, jobCtrlTrusted;
	logic        jobCtrlShareReq, jobCtrlAdvance, memFetchReq, memFetchAck, cmdReady, cmdError;
	logic        cmdValid, debugValid, engineReset, keysAvailable, sharingAllowed;
	logic [1:0]  jobSource, jobCtrlOrigin;
	logic [5:0]  descWriteIndex, jobCtrlStartIndex, jobCtrlLength;
	logic [31:0] descWriteData, descAddress, memFetchAddr, memFetchData, cmdWord;
	logic [3:0]  engineStateField;
	logic [31:0] bf [64];
	int          failCount = 0;
	int          samplesChecked = 0;

	dcp_claim_port u_dut (.*);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Inputs always change one nanosecond after the edge, so no race with the design.
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask : step

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wrapUp;
		if (failCount == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrapUp

	task automatic expire(string what);
		failCount++;
		$display("[ERR] %s expected completion seen timeout", what);
		wrapUp;
	endtask : expire

	task automatic waitHigh(ref logic s, input string what);
		for (int i = 0; i < 20 && s !== 1'b1; i++) begin
			step;
		end
		if (s !== 1'b1) begin
			expire(what);
		end
	endtask : waitHigh

	task automatic load(int st, int len);
		for (int i = st; i < st + len; i++) begin
			descWrite = 1'b1;
			descWriteIndex = 6'(i);
			descWriteData = $urandom;
			bf[i] = descWriteData;
			step;
		end
		descWrite = 1'b0;
	endtask : load

	task automatic advance;
		jobCtrlAdvance = 1'b1;
		step;
		jobCtrlAdvance = 1'b0;
	endtask : advance

	// Index one past the last word that must have come from memory.
	function automatic int fetchEnd(int st, int len, logic whole, logic four);
		int burst;
		burst = four ? 4 : 1;
		return (whole || burst >= len) ? st + burst : st + len;
	endfunction : fetchEnd

	// ****************************************
	// One direct job, with the memory side answered slowly
	// ****************************************
	task automatic runJob(int st, int len, logic whole, logic four, logic [1:0] org,
		logic tr, logic sh, logic inj, logic [3:0] expState);
		int n;
		int f;
		n = 0;
		f = st + (four ? 4 : 1);
		jobCtrlStartIndex = 6'(st);
		jobCtrlLength = 6'(len);
		jobCtrlWholeLoaded = whole;
		jobCtrlFourWord = four;
		jobCtrlOrigin = org;
		jobCtrlTrusted = tr;
		jobCtrlShareReq = sh;
		if (!whole) begin
			descAddress = $urandom & 32'hffff_fff0;
		end
		jobCtrlWrite = 1'b1;
		step;
		jobCtrlWrite = 1'b0;
		for (int c = 0; c < 200; c++) begin
			if (cmdValid === 1'b1) begin
				chk("cmdWord", cmdWord, bf[st + n]);
				n++;
			end
			if (engineStateField === 4'h0 || engineStateField === 4'hd) begin
				break;
			end
			chk("debugValid", debugValid, 32'h1);
			chk("jobAssign", jobAssign, 32'h0);
			cmdReady = 1'($urandom);
			cmdError = inj && engineStateField === 4'h2;
			if (memFetchReq === 1'b1 && memFetchAck !== 1'b1) begin
				chk("memFetchAddr", memFetchAddr, descAddress + 4 * (f - st));
				bf[f] = $urandom;
				memFetchData = bf[f];
				memFetchAck = 1'b1;
				f++;
			end else begin
				memFetchAck = 1'b0;
				memFetchData = ~memFetchData;
			end
			step;
		end
		memFetchAck = 1'b0;
		cmdError = 1'b0;
		if (engineStateField !== 4'h0 && engineStateField !== 4'hd) begin
			expire("runJob");
		end
		chk("engineStateField", engineStateField, expState);
		chk("memFetchReq", memFetchReq, 32'h0);
		if (expState == 4'h0) begin
			chk("fetchEnd", f, fetchEnd(st, len, whole, four));
			chk("wordsIssued", n, len);
			chk("debugValid", debugValid, 32'h0);
		end
	endtask : runJob

	initial begin
		#200000;
		expire("watchdog");
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int len;
		void'($urandom(32'h01192bb0));
		{rst, engineClaimRequest, ringJobValid, queuePortJobValid, integrityJobValid} = 5'h10;
		{normalJobDone, descWrite, jobCtrlWrite, jobCtrlWholeLoaded, jobCtrlFourWord} = 5'h00;
		{jobCtrlTrusted, jobCtrlShareReq, jobCtrlAdvance, memFetchAck, cmdError} = 5'h00;
		{jobCtrlOrigin, descWriteIndex, jobCtrlStartIndex} = 14'h0000;
		{descWriteData, descAddress, memFetchData} = 96'h0;
		jobCtrlLength = 6'h01;
		cmdReady = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk("engineClaimGranted", engineClaimGranted, 32'h0);
		chk("engineStateField", engineStateField, 32'h0);
		chk("keysAvailable", keysAvailable, 32'h1);
		chk("sharingAllowed", sharingAllowed, 32'h1);
		{ringJobValid, queuePortJobValid, integrityJobValid} = 3'h7;
		for (int k = 0; k < 4; k++) begin
			waitHigh(jobAssign, "jobAssign");
			chk("jobSource", jobSource, k % 3);
			step;
			chk("jobAssign", jobAssign, 32'h0);
			if (k < 3) begin
				normalJobDone = 1'b1;
				step;
				normalJobDone = 1'b0;
			end
		end
		// Claim while a normal job still occupies the engine; writes must start nothing.
		// Context and domain identifiers live outside this block; nothing to set first.
		engineClaimRequest = 1'b1;
		jobCtrlWholeLoaded = 1'b1;
		repeat (4) begin
			jobCtrlWrite = 1'b1;
			step;
			chk("engineClaimGranted", engineClaimGranted, 32'h0);
			chk("jobAssign", jobAssign, 32'h0);
			chk("engineStateField", engineStateField, 32'h0);
		end
		jobCtrlWrite = 1'b0;
		chk("keysAvailable", keysAvailable, 32'h0);
		chk("sharingAllowed", sharingAllowed, 32'h0);
		normalJobDone = 1'b1;
		step;
		normalJobDone = 1'b0;
		waitHigh(engineClaimGranted, "engineClaimGranted");
		chk("engineClaimGranted", engineClaimGranted, 32'h1);
		len = 1 + $urandom % 6;
		load(2, len);
		runJob(2, len, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
		load(0, 8);
		runJob(0, 8, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
		load(0, 3);
		runJob(0, 3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
		load(0, 4);
		runJob(0, 4, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 4'hd);
		repeat (2) step;
		chk("engineStateField", engineStateField, 32'hd);
		advance;
		chk("engineStateField", engineStateField, 32'h0);
		load(0, 4);
		runJob(0, 4, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
		// Every forbidden origin and mode ends in the error state; the last stays there.
		for (int b = 0; b < 5; b++) begin
			runJob(0, 4, 1'b1, 1'b1, (b < 3) ? 2'(b + 1) : 2'h0, b == 3, b == 4, 1'b0,
				4'hd);
			if (b < 4) begin
				advance;
			end
		end
		{ringJobValid, queuePortJobValid, integrityJobValid} = 3'h0;
		engineClaimRequest = 1'b0;
		step;
		chk("engineClaimGranted", engineClaimGranted, 32'h0);
		chk("engineReset", engineReset, 32'h1);
		chk("engineStateField", engineStateField, 32'h0);
		step;
		chk("engineReset", engineReset, 32'h0);
		chk("keysAvailable", keysAvailable, 32'h1);
		chk("sharingAllowed", sharingAllowed, 32'h1);
		// An idle engine is granted on the second edge after the request.
		engineClaimRequest = 1'b1;
		step;
		chk("engineClaimGranted", engineClaimGranted, 32'h0);
		step;
		chk("engineClaimGranted", engineClaimGranted, 32'h1);
		engineClaimRequest = 1'b0;
		step;
		step;
		queuePortJobValid = 1'b1;
		waitHigh(jobAssign, "jobAssign");
		chk("jobSource", jobSource, 32'h1);
		wrapUp;
	end
endmodule : test_dcp_claim_port
